// ---- rtl/bnec_pkg.sv ----
// Constants, code tables and helper functions for the band norm envelope coder
// How it works
// - Band norm is rms over first..last bin
// - Log quantizer, forty levels, 3 dB apart
// - Index is 34 minus twice log2 norm
// - Saturate band zero 0..31, others 0..39
// - Level is two to 17 minus half index
// - Lowest band index sent raw, five bits
// - Differences upper minus lower, kept in -15..16
// - Downward pass lifts too-negative lower index
// - Upward pass clamps differences above 16
// - Add 15 to get symbols 0..31
// - Cost normal and packing modes, take cheapest
// - Two-bit mode field, codes 0 to 3
// - Context: first from band zero, then previous
// - Packing mode writes five-bit symbols
// - Normal Huffman uses fixed 3..7 bit table
// - 26, 39 or 44 bands by bandwidth
// - Wideband edges for WB, default otherwise
package bnec_pkg;

	// Band counts per bandwidth
	localparam int BAND_MAX = 44;
	localparam int NB_WB    = 26;
	localparam int NB_SWB   = 39;
	localparam int NB_FB    = 44;

	// Widths
	localparam int IDX_W  = 6;
	localparam int COEF_W = 16;
	localparam int SUM_W  = 40;
	localparam int CODE_W = 7;
	localparam int LEN_W  = 3;
	localparam int COST_W = 16;
	localparam int LVL_W  = 32;

	// Bandwidth selector codes
	localparam logic [1:0] BW_WB  = 2'h0;
	localparam logic [1:0] BW_SWB = 2'h1;
	localparam logic [1:0] BW_FB  = 2'h2;

	// Quantizer
	localparam int QUANT_LEVELS   = 40;
	localparam int STEP_DB        = 3;
	localparam int NORM_UNITY_IDX = 34;
	localparam int IDX_MAX0       = 31;
	localparam int IDX_MAX        = QUANT_LEVELS - 1;
	localparam logic [15:0] SQRT2_Q15     = 16'hB505;
	localparam logic [15:0] SQRT_HALF_Q15 = 16'h5A82;
	localparam int LEVEL_FRAC    = 8;
	localparam int LEVEL_TOP_EXP = 17;

	// Differential coding
	localparam int DIFF_MIN   = -15;
	localparam int DIFF_MAX   = 16;
	localparam int SYM_OFFSET = 15;
	localparam int FIRST_W    = 5;
	localparam int MODE_W     = 2;
	localparam int PACK_W     = 5;

	// Coding modes
	localparam logic [1:0] MODE_CTX    = 2'h0;
	localparam logic [1:0] MODE_RESIZE = 2'h1;
	localparam logic [1:0] MODE_NORMAL = 2'h2;
	localparam logic [1:0] MODE_PACK   = 2'h3;
	localparam logic [COST_W-1:0] COST_NA = 16'hFFFF;

	// Band layout
	localparam logic [5:0] LEN_NARROW = 6'h08;
	localparam logic [5:0] LEN_MID    = 6'h10;
	localparam logic [5:0] LEN_WIDE   = 6'h18;
	localparam logic [5:0] LEN_TOP    = 6'h20;
	localparam int SPLIT_A = 16;
	localparam int SPLIT_B = 24;
	localparam int SPLIT_C = 36;

	// Bins in band b; WB has 32-bin top bands, default has 24 then 32
	function automatic logic [5:0] band_len(input logic wb, input logic [5:0] b);
		if (b < SPLIT_A)
			return LEN_NARROW;
		else if (b < SPLIT_B)
			return LEN_MID;
		else if (wb || b >= SPLIT_C)
			return LEN_TOP;
		return LEN_WIDE;
	endfunction

	// Difference symbol, offset into 0..31
	function automatic logic [4:0] diff_sym(input logic [5:0] hi, input logic [5:0] lo);
		logic [6:0] s;
		s = 7'({1'b0, hi}) - 7'({1'b0, lo}) + 7'(SYM_OFFSET);
		return s[4:0];
	endfunction

	// Reconstruction level in Q8: 2^(17 - i/2)
	function automatic logic [LVL_W-1:0] recon_level(input logic [5:0] i);
		logic [31:0] base;
		logic [47:0] p;
		base = 32'h0000_0001 << (LEVEL_FRAC + LEVEL_TOP_EXP - int'(i[5:1]));
		p = {16'h0000, base} * {32'h0000_0000, SQRT_HALF_Q15};
		return i[0] ? p[46:15] : base;
	endfunction

	// Normal Huffman table: {length, code right aligned}
	function automatic logic [9:0] huff_code(input logic [4:0] s);
		unique case (s)
			5'h00: return {3'h7, 7'h1A};
			5'h01: return {3'h7, 7'h3A};
			5'h02: return {3'h7, 7'h5A};
			5'h03: return {3'h7, 7'h7A};
			5'h04: return {3'h7, 7'h1B};
			5'h05: return {3'h7, 7'h3B};
			5'h06: return {3'h7, 7'h5B};
			5'h07: return {3'h7, 7'h7B};
			5'h08: return {3'h6, 7'h0C};
			5'h09: return {3'h6, 7'h1C};
			5'h0A: return {3'h6, 7'h2C};
			5'h0B: return {3'h6, 7'h3C};
			5'h0C: return {3'h4, 7'h02};
			5'h0D: return {3'h4, 7'h06};
			5'h0E: return {3'h3, 7'h04};
			5'h0F: return {3'h3, 7'h06};
			5'h10: return {3'h3, 7'h00};
			5'h11: return {3'h3, 7'h02};
			5'h12: return {3'h4, 7'h0A};
			5'h13: return {3'h4, 7'h0E};
			5'h14: return {3'h6, 7'h0E};
			5'h15: return {3'h6, 7'h1E};
			5'h16: return {3'h6, 7'h2E};
			5'h17: return {3'h6, 7'h3E};
			5'h18: return {3'h7, 7'h1E};
			5'h19: return {3'h7, 7'h3E};
			5'h1A: return {3'h7, 7'h5E};
			5'h1B: return {3'h7, 7'h7E};
			5'h1C: return {3'h7, 7'h1F};
			5'h1D: return {3'h7, 7'h3F};
			5'h1E: return {3'h7, 7'h5F};
			5'h1F: return {3'h7, 7'h7F};
		endcase
	endfunction

endpackage

// ---- rtl/bnec_nq_if.sv ----
// Handshake between the envelope controller and the norm quantizer
`timescale 1ns/1ns
`default_nettype none
interface bnec_nq_if import bnec_pkg::*; ();
	logic             start;
	logic [SUM_W-1:0] sum;
	logic [5:0]       len;
	logic             first_band;
	logic             done;
	logic [IDX_W-1:0] idx;

	modport ctrl  (output start, sum, len, first_band, input done, idx);
	modport quant (input start, sum, len, first_band, output done, idx);
endinterface
`default_nettype wire

// ---- rtl/bnec_norm_quant.sv ----
// Mean square division and log2 quantization of one band norm
`timescale 1ns/1ns
`default_nettype none
module bnec_norm_quant import bnec_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Request and result
	bnec_nq_if.quant nq
);
	typedef enum logic [1:0] {Q_IDLE, Q_DIV, Q_LOG} bnec_qst_t;

	bnec_qst_t        st_r, st_nxt;
	logic [SUM_W-1:0] quo_r, quo_nxt;
	logic [6:0]       rem_r, rem_nxt;
	logic [5:0]       cnt_r, cnt_nxt;
	logic [5:0]       len_r, len_nxt;
	logic             first_r, first_nxt;
	logic             done_r, done_nxt;
	logic [IDX_W-1:0] idx_r, idx_nxt;

	assign nq.done = done_r;
	assign nq.idx  = idx_r;

	function automatic int msb_pos(input logic [SUM_W-1:0] v);
		int p;
		p = 0;
		for (int i = 0; i < SUM_W; i++)
			if (v[i])
				p = i;
		return p;
	endfunction

	// Restoring divide by band length, one quotient bit per cycle, then log
	always_comb begin
		logic [6:0]       r2;
		logic [SUM_W-1:0] norm;
		int               n;
		int               v;
		int               lim;
		r2        = '0;
		norm      = '0;
		n         = 0;
		v         = 0;
		lim       = 0;
		st_nxt    = st_r;
		quo_nxt   = quo_r;
		rem_nxt   = rem_r;
		cnt_nxt   = cnt_r;
		len_nxt   = len_r;
		first_nxt = first_r;
		idx_nxt   = idx_r;
		done_nxt  = 1'b0;
		unique case (st_r)
			Q_IDLE: begin
				if (nq.start) begin
					quo_nxt   = nq.sum;
					rem_nxt   = '0;
					cnt_nxt   = '0;
					len_nxt   = nq.len;
					first_nxt = nq.first_band;
					st_nxt    = Q_DIV;
				end
			end
			Q_DIV: begin
				// Mean of squares over band length
				r2 = {rem_r[5:0], quo_r[SUM_W-1]};
				if (r2 >= {1'b0, len_r}) begin
					rem_nxt = r2 - {1'b0, len_r};
					quo_nxt = {quo_r[SUM_W-2:0], 1'b1};
				end else begin
					rem_nxt = r2;
					quo_nxt = {quo_r[SUM_W-2:0], 1'b0};
				end
				cnt_nxt = cnt_r + 6'h01;
				if (cnt_r == 6'(SUM_W - 1))
					st_nxt = Q_LOG;
			end
			Q_LOG: begin
				// Round log2 of mean square to nearest step: mantissa vs sqrt2
				n    = msb_pos(quo_r);
				norm = quo_r << (SUM_W - 1 - n);
				if (norm[SUM_W-1 -: 16] >= SQRT2_Q15)
					n = n + 1;
				v = NORM_UNITY_IDX - n;
				if (quo_r == '0)
					v = IDX_MAX;
				lim = first_r ? IDX_MAX0 : IDX_MAX;
				if (v < 0)
					v = 0;
				if (v > lim)
					v = lim;
				idx_nxt  = IDX_W'(v);
				done_nxt = 1'b1;
				st_nxt   = Q_IDLE;
			end
		endcase
	end

	// State registers
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r    <= Q_IDLE;
			quo_r   <= '0;
			rem_r   <= '0;
			cnt_r   <= '0;
			len_r   <= '0;
			first_r <= 1'b0;
			done_r  <= 1'b0;
			idx_r   <= '0;
		end else begin
			st_r    <= st_nxt;
			quo_r   <= quo_nxt;
			rem_r   <= rem_nxt;
			cnt_r   <= cnt_nxt;
			len_r   <= len_nxt;
			first_r <= first_nxt;
			done_r  <= done_nxt;
			idx_r   <= idx_nxt;
		end
	end
endmodule
`default_nettype wire

// ---- rtl/bnec_envelope_coder.sv ----
// Band norm envelope coder: band loop, difference limiting, mode choice, emission
`timescale 1ns/1ns
`default_nettype none
module bnec_envelope_coder import bnec_pkg::*; #(
	parameter logic [IDX_W-1:0] CTX_BASE_OFFSET = 6'h00
) (
	// Clock and reset
	input  wire logic                 CORE_CLK,
	input  wire logic                 RESET,
	// Frame control
	input  wire logic                 START,
	input  wire logic [1:0]           BANDWIDTH,
	output logic                      BUSY,
	output logic                      DONE,
	// Coefficients from the transform stage
	input  wire logic                 COEF_VALID,
	input  wire logic [COEF_W-1:0]    COEF_DATA,
	output logic                      COEF_READY,
	// Coded words to the bitstream writer
	output logic                      OUT_VALID,
	input  wire logic                 OUT_READY,
	output logic [CODE_W-1:0]         OUT_DATA,
	output logic [LEN_W-1:0]          OUT_LEN,
	output logic signed [IDX_W:0]     OUT_CTX,
	output logic [LVL_W-1:0]          OUT_LEVEL
);
	typedef enum logic [2:0] {S_IDLE, S_ACC, S_QWAIT, S_PASS1, S_PASS2, S_COST, S_PICK, S_EMIT} bnec_st_t;

	bnec_st_t             st_r, st_nxt;
	logic [5:0]           band_r, band_nxt;
	logic [5:0]           bin_r, bin_nxt;
	logic [5:0]           nb_r, nb_nxt;
	logic                 wb_r, wb_nxt;
	logic [SUM_W-1:0]     sum_r, sum_nxt;
	logic                 qgo_r, qgo_nxt;
	logic [IDX_W-1:0]     idx_r [BAND_MAX];
	logic [IDX_W-1:0]     idx_nxt [BAND_MAX];
	logic [COST_W-1:0]    cost_r, cost_nxt;
	logic [1:0]           mode_r, mode_nxt;
	logic [5:0]           emit_r, emit_nxt;
	logic                 busy_r, done_r, ready_r, ovalid_r;
	logic                 done_nxt, ovalid_nxt;
	logic [CODE_W-1:0]    odata_r, odata_nxt;
	logic [LEN_W-1:0]     olen_r, olen_nxt;
	logic signed [IDX_W:0] octx_r, octx_nxt;
	logic [LVL_W-1:0]     olvl_r, olvl_nxt;
	logic [2*COEF_W-1:0]  sq;

	bnec_nq_if nq ();

	bnec_norm_quant u_quant (
		.clk (CORE_CLK),
		.rst (RESET),
		.nq  (nq.quant)
	);

	// Quantizer request: sum is already complete when the pulse arrives
	assign nq.start      = qgo_r;
	assign nq.sum        = sum_r;
	assign nq.len        = band_len(wb_r, band_r);
	assign nq.first_band = (band_r == '0);
	assign sq            = 32'($signed(COEF_DATA) * $signed(COEF_DATA));

	assign BUSY       = busy_r;
	assign DONE       = done_r;
	assign COEF_READY = ready_r;
	assign OUT_VALID  = ovalid_r;
	assign OUT_DATA   = odata_r;
	assign OUT_LEN    = olen_r;
	assign OUT_CTX    = octx_r;
	assign OUT_LEVEL  = olvl_r;

	// Frame sequencing, limiting passes, costing and emission
	always_comb begin
		logic signed [6:0] d;
		logic [4:0]        s;
		logic [9:0]        hc;
		logic [5:0]        b;
		logic [5:0]        bp;
		logic [COST_W-1:0] c [4];
		logic [COST_W-1:0] best;
		logic              slot;
		d = '0;
		s = '0;
		hc = '0;
		b = '0;
		bp = '0;
		best = '0;
		c = '{default: '0};
		slot       = !ovalid_r || OUT_READY;
		st_nxt     = st_r;
		band_nxt   = band_r;
		bin_nxt    = bin_r;
		nb_nxt     = nb_r;
		wb_nxt     = wb_r;
		sum_nxt    = sum_r;
		qgo_nxt    = 1'b0;
		idx_nxt    = idx_r;
		cost_nxt   = cost_r;
		mode_nxt   = mode_r;
		emit_nxt   = emit_r;
		done_nxt   = 1'b0;
		ovalid_nxt = ovalid_r && !OUT_READY;
		odata_nxt  = odata_r;
		olen_nxt   = olen_r;
		octx_nxt   = octx_r;
		olvl_nxt   = olvl_r;
		unique case (st_r)
			S_IDLE: begin
				if (START) begin
					// Band count and edge table follow the bandwidth
					wb_nxt   = (BANDWIDTH == BW_WB);
					nb_nxt   = (BANDWIDTH == BW_WB) ? 6'(NB_WB) : (BANDWIDTH == BW_SWB) ? 6'(NB_SWB) : 6'(NB_FB);
					band_nxt = '0;
					bin_nxt  = '0;
					sum_nxt  = '0;
					st_nxt   = S_ACC;
				end
			end
			S_ACC: begin
				if (COEF_VALID) begin
					sum_nxt = sum_r + SUM_W'(sq);
					bin_nxt = bin_r + 6'h01;
					if (bin_r == band_len(wb_r, band_r) - 6'h01) begin
						qgo_nxt = 1'b1;
						st_nxt  = S_QWAIT;
					end
				end
			end
			S_QWAIT: begin
				if (nq.done) begin
					idx_nxt[band_r] = nq.idx;
					sum_nxt  = '0;
					bin_nxt  = '0;
					band_nxt = band_r + 6'h01;
					st_nxt   = S_ACC;
					if (band_r == nb_r - 6'h01) begin
						band_nxt = nb_r - 6'h02;
						st_nxt   = S_PASS1;
					end
				end
			end
			S_PASS1: begin
				// Downward: too-negative step pulls the lower index to the upper
				d = 7'({1'b0, idx_r[band_r + 6'h01]}) - 7'({1'b0, idx_r[band_r]});
				if (d < 7'(DIFF_MIN))
					idx_nxt[band_r] = idx_r[band_r + 6'h01];
				band_nxt = band_r - 6'h01;
				if (band_r == '0) begin
					band_nxt = '0;
					st_nxt   = S_PASS2;
				end
			end
			S_PASS2: begin
				// Upward: clamp rises, using indices already fixed below
				d = 7'({1'b0, idx_r[band_r + 6'h01]}) - 7'({1'b0, idx_r[band_r]});
				if (d > 7'(DIFF_MAX))
					idx_nxt[band_r + 6'h01] = idx_r[band_r] + 6'(DIFF_MAX);
				band_nxt = band_r + 6'h01;
				if (band_r == nb_r - 6'h02) begin
					band_nxt = '0;
					cost_nxt = '0;
					st_nxt   = S_COST;
				end
			end
			S_COST: begin
				s  = diff_sym(idx_r[band_r + 6'h01], idx_r[band_r]);
				hc = huff_code(s);
				cost_nxt = cost_r + COST_W'(hc[9:7]);
				band_nxt = band_r + 6'h01;
				if (band_r == nb_r - 6'h02)
					st_nxt = S_PICK;
			end
			S_PICK: begin
				// Context and re-sized tables live outside this block, so their cost is unavailable
				c[0] = COST_NA;
				c[1] = COST_NA;
				c[2] = cost_r;
				c[3] = COST_W'(PACK_W * (nb_r - 6'h01));
				best = COST_NA;
				mode_nxt = MODE_CTX;
				for (int m = 0; m < 4; m++) begin
					if (c[m] < best) begin
						best     = c[m];
						mode_nxt = 2'(m);
					end
				end
				emit_nxt = '0;
				st_nxt   = S_EMIT;
			end
			S_EMIT: begin
				if (slot) begin
					emit_nxt   = emit_r + 6'h01;
					ovalid_nxt = 1'b1;
					octx_nxt   = '0;
					if (emit_r == nb_r + 6'h01) begin
						// Last word has been taken
						ovalid_nxt = 1'b0;
						done_nxt   = 1'b1;
						st_nxt     = S_IDLE;
					end else if (emit_r == '0) begin
						odata_nxt = CODE_W'(idx_r[0][FIRST_W-1:0]);
						olen_nxt  = LEN_W'(FIRST_W);
						olvl_nxt  = recon_level(idx_r[0]);
					end else if (emit_r == 6'h01) begin
						odata_nxt = CODE_W'(mode_r);
						olen_nxt  = LEN_W'(MODE_W);
						olvl_nxt  = '0;
					end else begin
						// Symbols in ascending band order
						b  = emit_r - 6'h02;
						bp = (b == '0) ? 6'h00 : b - 6'h01;
						s  = diff_sym(idx_r[b + 6'h01], idx_r[b]);
						hc = huff_code(s);
						olvl_nxt = recon_level(idx_r[b + 6'h01]);
						if (b == '0)
							octx_nxt = 7'({1'b0, idx_r[0]}) - 7'({1'b0, CTX_BASE_OFFSET});
						else
							octx_nxt = 7'(diff_sym(idx_r[b], idx_r[bp])) - 7'(SYM_OFFSET);
						if (mode_r == MODE_NORMAL) begin
							odata_nxt = hc[6:0];
							olen_nxt  = hc[9:7];
						end else begin
							odata_nxt = CODE_W'(s);
							olen_nxt  = LEN_W'(PACK_W);
						end
					end
				end
			end
		endcase
	end

	// State registers; ready and busy are decoded from the next state
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			st_r     <= S_IDLE;
			band_r   <= '0;
			bin_r    <= '0;
			nb_r     <= '0;
			wb_r     <= 1'b0;
			sum_r    <= '0;
			qgo_r    <= 1'b0;
			idx_r    <= '{default: '0};
			cost_r   <= '0;
			mode_r   <= MODE_CTX;
			emit_r   <= '0;
			busy_r   <= 1'b0;
			done_r   <= 1'b0;
			ready_r  <= 1'b0;
			ovalid_r <= 1'b0;
			odata_r  <= '0;
			olen_r   <= '0;
			octx_r   <= '0;
			olvl_r   <= '0;
		end else begin
			st_r     <= st_nxt;
			band_r   <= band_nxt;
			bin_r    <= bin_nxt;
			nb_r     <= nb_nxt;
			wb_r     <= wb_nxt;
			sum_r    <= sum_nxt;
			qgo_r    <= qgo_nxt;
			idx_r    <= idx_nxt;
			cost_r   <= cost_nxt;
			mode_r   <= mode_nxt;
			emit_r   <= emit_nxt;
			busy_r   <= (st_nxt != S_IDLE);
			done_r   <= done_nxt;
			ready_r  <= (st_nxt == S_ACC);
			ovalid_r <= ovalid_nxt;
			odata_r  <= odata_nxt;
			olen_r   <= olen_nxt;
			octx_r   <= octx_nxt;
			olvl_r   <= olvl_nxt;
		end
	end
endmodule
`default_nettype wire

// ---- sim/bnec_env_assertions.sv ----
// Port-level protocol and framing checks for the envelope coder
`timescale 1ns/1ns
`default_nettype none
module bnec_env_assertions import bnec_pkg::*; (
	// Clock, reset and frame control
	input wire logic              CORE_CLK,
	input wire logic              RESET,
	input wire logic              START,
	input wire logic [1:0]        BANDWIDTH,
	input wire logic              BUSY,
	input wire logic              DONE,
	// Streams
	input wire logic              COEF_READY,
	input wire logic              OUT_VALID,
	input wire logic              OUT_READY,
	input wire logic [CODE_W-1:0] OUT_DATA,
	input wire logic [LEN_W-1:0]  OUT_LEN,
	input wire logic [LVL_W-1:0]  OUT_LEVEL
);
	logic [5:0] words_r;
	logic [5:0] words_nxt;
	logic [5:0] nb_r;
	logic [5:0] nb_nxt;
	logic [1:0] mode_r;
	logic [1:0] mode_nxt;
	logic       take;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RESET);

	assign take = OUT_VALID && OUT_READY;

	// Words taken and mode seen in this frame; band count latched when a start is accepted
	always_comb begin
		words_nxt = take ? words_r + 6'h01 : words_r;
		mode_nxt = (take && words_r == 6'h01) ? OUT_DATA[1:0] : mode_r;
		nb_nxt = nb_r;
		if (START && !BUSY) begin
			words_nxt = 6'h00;
			nb_nxt = (BANDWIDTH == BW_WB) ? 6'(NB_WB) : (BANDWIDTH == BW_SWB) ? 6'(NB_SWB) : 6'(NB_FB);
		end
	end

	// Cleared on reset so an aborted frame leaves nothing behind
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			words_r <= 6'h00;
			nb_r <= 6'h00;
			mode_r <= 2'h0;
		end else begin
			words_r <= words_nxt;
			nb_r <= nb_nxt;
			mode_r <= mode_nxt;
		end
	end

	done_pulse_a: assert property (DONE |=> !DONE)
		else $error("done held longer than one cycle");
	done_count_a: assert property (DONE |-> words_r == nb_r + 6'h01 && !BUSY)
		else $error("frame ended with a wrong word count");
	word_hold_a: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA) && $stable(OUT_LEN)
		&& $stable(OUT_LEVEL)) else $error("stalled word changed");
	first_word_a: assert property (OUT_VALID && words_r == 6'h00 |-> OUT_LEN == 3'h5 && OUT_DATA[6:5] == 2'h0)
		else $error("first word is not a five bit index");
	mode_word_a: assert property (OUT_VALID && words_r == 6'h01 |-> OUT_LEN == 3'h2 && OUT_LEVEL == 32'h0000_0000
		&& OUT_DATA[6:2] == 5'h00 && OUT_DATA[1:0] >= MODE_NORMAL) else $error("bad mode word");
	pack_len_a: assert property (OUT_VALID && words_r > 6'h01 && mode_r == MODE_PACK |-> OUT_LEN == 3'h5)
		else $error("packed symbol not five bits");
	huff_len_a: assert property (OUT_VALID && words_r > 6'h01 && mode_r == MODE_NORMAL |-> OUT_LEN >= 3'h3)
		else $error("prefix code shorter than three bits");
	last_done_a: assert property (take && words_r == nb_r |-> ##[1:3] DONE)
		else $error("no done after last word");
	idle_quiet_a: assert property (!BUSY |-> !OUT_VALID && !COEF_READY)
		else $error("activity while idle");
	start_busy_a: assert property (START && !BUSY |=> BUSY)
		else $error("start not taken");

	cover property (DONE && mode_r == MODE_PACK);
	cover property (OUT_VALID && !OUT_READY);
	cover property (DONE && nb_r == 6'(NB_FB));
endmodule
bind bnec_envelope_coder bnec_env_assertions chk (.CORE_CLK, .RESET, .START, .BANDWIDTH, .BUSY, .DONE,
	.COEF_READY, .OUT_VALID, .OUT_READY, .OUT_DATA, .OUT_LEN, .OUT_LEVEL);
`default_nettype wire

// ---- sim/bnec_env_peer.sv ----
// Coefficient source and bitstream writer standing on both sides of the coder
`timescale 1ns/1ns
`default_nettype none
module bnec_env_peer import bnec_pkg::*; (
	// Clock, reset and pacing
	input wire logic                  clk,
	input wire logic                  rst,
	input wire logic                  frame,
	input wire logic                  slow,
	input wire logic                  wb,
	input wire logic [5:0]            nb,
	// Coefficient side
	output logic                      coef_valid,
	output logic [COEF_W-1:0]         coef_data,
	input wire logic                  coef_ready,
	// Word side
	input wire logic                  out_valid,
	output logic                      out_ready,
	input wire logic [CODE_W-1:0]     out_data,
	input wire logic [LEN_W-1:0]      out_len,
	input wire logic signed [IDX_W:0] out_ctx,
	input wire logic [LVL_W-1:0]      out_level
);
	logic [COEF_W-1:0] amp [BAND_MAX];
	logic [9:0]        wq [$];
	logic [6:0]        cq [$];
	logic [LVL_W-1:0]  lq [$];
	int                band;
	int                pos;
	int                taken;
	int                cyc;
	logic              go;

	// Bins per band: narrow low bands, wider top bands for wideband
	function automatic int blen(input int b);
		if (b < 16)
			return 8;
		if (b < 24)
			return 16;
		return (wb || b >= 36) ? 32 : 24;
	endfunction

	initial begin
		coef_valid = 1'b0;
		coef_data = 16'h0000;
		out_ready = 1'b0;
	end

	// A refused coefficient is held; an idle data bus toggles so stale values never pass
	always @(posedge clk) begin
		cyc++;
		if (out_valid && out_ready && !rst) begin
			wq.push_back({out_len, out_data});
			cq.push_back(out_ctx);
			lq.push_back(out_level);
		end
		out_ready <= #1 !rst && (!slow || cyc[0]);
		if (rst || frame) begin
			band = 0;
			pos = 0;
			taken = 0;
			wq.delete();
			cq.delete();
			lq.delete();
			coef_valid <= #1 1'b0;
		end else begin
			if (coef_valid && coef_ready) begin
				taken++;
				pos++;
				if (pos == blen(band)) begin
					pos = 0;
					band++;
				end
			end
			if (!(coef_valid && !coef_ready)) begin
				go = band < nb && (!slow || cyc[1:0] != 2'h0);
				coef_valid <= #1 go;
				coef_data <= #1 go ? (pos[0] ? -amp[band] : amp[band]) : ~coef_data;
			end
		end
	end
endmodule
`default_nettype wire

// ---- sim/bnec_envelope_coder_bench.sv ----
// Self-checking bench: whole frames through the envelope coder
`timescale 1ns/1ns
`default_nettype none
module bnec_envelope_coder_bench import bnec_pkg::*; ;
	logic                  clk;
	logic                  rst;
	logic                  start;
	logic                  arm;
	logic [1:0]            bw;
	logic                  slow;
	logic                  wb;
	logic [5:0]            nb;
	logic                  busy;
	logic                  done;
	logic                  cv;
	logic [COEF_W-1:0]     cd;
	logic                  cr;
	logic                  ov;
	logic                  ordy;
	logic [CODE_W-1:0]     od;
	logic [LEN_W-1:0]      ol;
	logic signed [IDX_W:0] oc;
	logic [LVL_W-1:0]      olv;
	logic [4:0]            exp_sym [$];
	int                    err_count;
	int                    checked;
	int                    cycles;

	bnec_envelope_coder dut (.CORE_CLK(clk), .RESET(rst), .START(start), .BANDWIDTH(bw), .BUSY(busy), .DONE(done),
		.COEF_VALID(cv), .COEF_DATA(cd), .COEF_READY(cr), .OUT_VALID(ov), .OUT_READY(ordy), .OUT_DATA(od),
		.OUT_LEN(ol), .OUT_CTX(oc), .OUT_LEVEL(olv));
	bnec_env_peer peer (.clk(clk), .rst(rst), .frame(arm), .slow(slow), .wb(wb), .nb(nb), .coef_valid(cv),
		.coef_data(cd), .coef_ready(cr), .out_valid(ov), .out_ready(ordy), .out_data(od), .out_len(ol),
		.out_ctx(oc), .out_level(olv));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Hang guard: frames take a few thousand cycles each
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			err_count++;
			end_of_test;
		end
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Only the prefix codes these frames produce
	function automatic logic [9:0] hcode(input logic [4:0] s);
		case (s)
			5'h0F: return {3'h3, 7'h06};
			5'h10: return {3'h3, 7'h00};
			5'h1F: return {3'h7, 7'h7F};
			default: return 10'h3FF;
		endcase
	endfunction

	task automatic fill(input int lo, input int hi, input logic [15:0] a);
		for (int i = lo; i <= hi; i++)
			peer.amp[i] = a;
	endtask

	// One frame; a stray start can be thrown in while the coder is busy
	task automatic run(input logic [1:0] b, input logic s, input int n, input logic stray);
		int i;
		@(posedge clk);
		#1;
		bw = b;
		slow = s;
		nb = 6'(n);
		wb = (b == BW_WB);
		start = 1'b1;
		arm = 1'b1;
		for (i = 0; i < 20000 && done !== 1'b1; i++) begin
			@(posedge clk);
			#1;
			arm = 1'b0;
			start = stray && i == 100;
			bw = stray ? BW_WB : b;
		end
		cmp(32'(done), 32'h1);
	endtask

	// Expected words follow the index chain from the first index through each symbol
	task automatic judge(input logic [4:0] first, input logic [1:0] mode);
		logic [5:0] ix;
		logic [6:0] ctx;
		cmp(32'(peer.wq.size()), 32'(exp_sym.size() + 2));
		if (peer.wq.size() != exp_sym.size() + 2)
			return;
		cmp(32'(peer.wq[0]), {22'h0, 3'h5, 2'h0, first});
		cmp(32'(peer.wq[1]), {22'h0, 3'h2, 5'h00, mode});
		cmp(peer.lq[1], 32'h0000_0000);
		ix = 6'(first);
		ctx = 7'(first);
		if (!ix[0])
			cmp(peer.lq[0], 32'h1 << (25 - ix[5:1]));
		foreach (exp_sym[k]) begin
			cmp(32'(peer.wq[k + 2]), 32'(mode == MODE_PACK ? {3'h5, 2'h0, exp_sym[k]} : hcode(exp_sym[k])));
			cmp(32'(peer.cq[k + 2]), 32'(ctx));
			ix = ix + 6'(exp_sym[k]) - 6'h0F;
			if (!ix[0])
				cmp(peer.lq[k + 2], 32'h1 << (25 - ix[5:1]));
			ctx = 7'(exp_sym[k]) - 7'h0F;
		end
	endtask

	// Flat spectrum at 256: every band at index 18, all steps zero, prompt writer
	task automatic t_flat;
		fill(0, 43, 16'h0100);
		exp_sym = {};
		repeat (25) exp_sym.push_back(5'h0F);
		run(BW_WB, 1'b0, 26, 1'b0);
		judge(5'h12, MODE_NORMAL);
		cmp(32'(peer.taken), 32'd320);
		$display("test flat_wb done");
	endtask

	// Silent even bands saturate (band zero at 31, the rest at 39) between odd bands at 26;
	// every step after the first then needs a seven-bit prefix code, so packing wins
	task automatic t_zero;
		fill(0, 43, 16'h0000);
		for (int i = 1; i < 26; i += 2)
			peer.amp[i] = 16'h0010;
		exp_sym = {5'h0A};
		repeat (12) begin
			exp_sym.push_back(5'h1C);
			exp_sym.push_back(5'h02);
		end
		run(BW_WB, 1'b1, 26, 1'b0);
		judge(5'h1F, MODE_PACK);
		$display("test zero_wb done");
	endtask

	// Loud band zero, silent above: steep rises are clamped upward band by band
	task automatic t_rise;
		fill(0, 43, 16'h0000);
		fill(0, 0, 16'h4000);
		exp_sym = {5'h1F, 5'h1F, 5'h10};
		repeat (40) exp_sym.push_back(5'h0F);
		run(BW_FB, 1'b1, 44, 1'b0);
		judge(5'h06, MODE_NORMAL);
		cmp(32'(peer.taken), 32'd800);
		$display("test rise_fb done");
	endtask

	// Silent gap under a loud top: deep drops lift the lower bands; stray start ignored
	task automatic t_drop;
		fill(0, 43, 16'h0000);
		fill(0, 0, 16'h0100);
		fill(20, 38, 16'h0100);
		exp_sym = {};
		repeat (38) exp_sym.push_back(5'h0F);
		run(BW_SWB, 1'b0, 39, 1'b1);
		judge(5'h12, MODE_NORMAL);
		cmp(32'(peer.taken), 32'd640);
		$display("test drop_swb done");
	endtask

	// Reset in mid-frame quiets busy, done, coefficient ready and output valid
	task automatic t_reset;
		@(posedge clk);
		#1;
		bw = BW_FB;
		nb = 6'h2C;
		wb = 1'b0;
		start = 1'b1;
		arm = 1'b1;
		@(posedge clk);
		#1;
		start = 1'b0;
		arm = 1'b0;
		repeat (150) @(posedge clk);
		#1 rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		cmp({28'h0, busy, done, cr, ov}, 32'h0000_0000);
		$display("test reset_mid done");
	endtask

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		start = 1'b0;
		arm = 1'b0;
		bw = 2'h0;
		slow = 1'b0;
		wb = 1'b0;
		nb = 6'h00;
		repeat (8) @(posedge clk);
		#1 rst = 1'b0;
		t_flat;
		t_zero;
		t_rise;
		t_drop;
		t_reset;
		t_flat;
		end_of_test;
	end
endmodule
`default_nettype wire
